// ### dv/core_model.sv
// core side: random fetch and data check requests while run is high
`timescale 1ns/1ps
module core_model (
    input  wire        ref_clk,
    input  wire        run,
    output reg         if_req = 1'b0,
    output reg  [31:0] if_addr = 32'h0,
    output reg         if_priv = 1'b0,
    output reg         da_req = 1'b0,
    output reg  [31:0] da_addr = 32'h0,
    output reg         da_priv = 1'b0,
    output reg         da_write = 1'b0
);
    integer    seed = 76;
    reg [31:0] r;
    // request drawn at random each cycle; addresses keep moving while idle
    always @(posedge ref_clk) begin
        r = $random(seed);
        if_req <= run & r[0];
        da_req <= run & r[1];
        if_priv <= r[2];
        da_priv <= r[3];
        da_write <= r[4];
        if_addr <= $random(seed) & (r[5] ? 32'hFFFFFFFF : 32'h0003FFFF);
        da_addr <= $random(seed) & (r[6] ? 32'hFFFFFFFF : 32'h0003FFFF);
    end
endmodule

// ### dv/region_protection_unit_monitor.sv
// port checker for the region protection unit
`timescale 1ns/1ps
module region_protection_unit_monitor (
    input wire        ref_clk,
    input wire        sys_rst,
    input wire        cp_wr,
    input wire        cp_rd,
    input wire [3:0]  cp_reg,
    input wire [31:0] cp_wdata,
    input wire [31:0] cp_rdata,
    input wire        cp_rvalid,
    input wire        if_req,
    input wire        if_valid,
    input wire        if_abort,
    input wire        if_cachable,
    input wire        da_req,
    input wire        da_valid,
    input wire        da_abort,
    input wire        da_cachable,
    input wire        da_bufferable,
    input wire        unit_enabled
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // read taken, then answered one cycle later
    sequence s_rd_take; cp_rd; endsequence
    sequence s_rd_answer; cp_rvalid; endsequence
    property p_rd_answer; s_rd_take |=> s_rd_answer; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read not answered");
    property p_rd_quiet; !cp_rd |=> !cp_rvalid; endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("stray read answer");
    property p_unmapped;
        cp_rd && !(cp_reg inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6}) |=> cp_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_unused; cp_rd && cp_reg == 4'h6 |=> cp_rdata[11:6] == 6'h0; endproperty
    a_unused: assert property (p_unused)
        else $error("unused region bits set");
    property p_enable;
        cp_wr && cp_reg == 4'h1 |=> ##1 unit_enabled == $past(cp_wdata[0], 2);
    endproperty
    a_enable: assert property (p_enable)
        else $error("enable does not follow control bit");
    property p_if_off;
        if_req |=> if_valid && (unit_enabled || (!if_abort && !if_cachable));
    endproperty
    a_if_off: assert property (p_if_off)
        else $error("fetch attributes while disabled");
    property p_da_off;
        da_req |=> da_valid && (unit_enabled || (!da_abort && !da_cachable && !da_bufferable));
    endproperty
    a_da_off: assert property (p_da_off)
        else $error("data attributes while disabled");
    property p_if_abort; if_abort |-> if_valid && !if_cachable; endproperty
    a_if_abort: assert property (p_if_abort)
        else $error("bad prefetch abort");
    property p_da_abort; da_abort |-> da_valid && !da_cachable && !da_bufferable; endproperty
    a_da_abort: assert property (p_da_abort)
        else $error("bad data abort");
endmodule

bind region_protection_unit region_protection_unit_monitor i_mon (.ref_clk, .sys_rst, .cp_wr,
    .cp_rd, .cp_reg, .cp_wdata, .cp_rdata, .cp_rvalid, .if_req, .if_valid, .if_abort,
    .if_cachable, .da_req, .da_valid, .da_abort, .da_cachable, .da_bufferable, .unit_enabled);

// ### dv/region_protection_unit_tb_top.sv
// self-checking bench of the region protection unit
`timescale 1ns/1ps
module region_protection_unit_tb_top;
    reg         ref_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         cp_wr = 1'b0;
    reg         cp_rd = 1'b0;
    reg  [3:0]  cp_reg = 4'h0;
    reg  [2:0]  cp_opc2 = 3'h0;
    reg  [2:0]  cp_crm = 3'h0;
    reg  [31:0] cp_wdata = 32'h0;
    reg         run = 1'b0;
    reg         en = 1'b0;
    reg  [3:0]  exp_if = 4'h0;
    reg  [3:0]  exp_da = 4'h0;
    reg  [31:0] rgn [0:7];
    reg  [31:0] attr [0:4];
    reg  [31:0] v;
    integer     seed = 76;
    integer     mismatches = 0;
    integer     checked = 0;
    integer     k, j, s, round;
    wire [31:0] cp_rdata, if_addr, da_addr;
    wire        cp_rvalid, if_req, if_priv, if_valid, if_abort, if_cachable, unit_enabled;
    wire        da_req, da_priv, da_write, da_valid, da_abort, da_cachable, da_bufferable;

    always #2 ref_clk = ~ref_clk;

    region_protection_unit #(.NUM_REGIONS(8)) i_region_protection_unit (.ref_clk, .sys_rst,
        .cp_wr, .cp_rd, .cp_reg, .cp_opc2, .cp_crm, .cp_wdata, .cp_rdata, .cp_rvalid, .if_req,
        .if_addr, .if_priv, .if_valid, .if_abort, .if_cachable, .da_req, .da_addr, .da_priv,
        .da_write, .da_valid, .da_abort, .da_cachable, .da_bufferable, .unit_enabled);
    core_model i_core_model (.ref_clk, .run, .if_req, .if_addr, .if_priv, .da_req, .da_addr,
        .da_priv, .da_write);

    // reference check: returns abort, cachable, bufferable
    function automatic [2:0] model(input [31:0] a, input p, input w, input ins);
        integer    i, hit;
        reg [1:0]  pm;
        reg [32:0] msk;
        begin
            model = 3'h0;
            if (en) begin
                hit = -1;
                for (i = 0; i < 8; i = i + 1) begin
                    msk = 33'h1FFFFFFFF << (rgn[i][5:1] + 1);
                    if (rgn[i][0] && ((a ^ rgn[i]) & msk[31:0]) == 32'h0) hit = i;
                end
                model = 3'h4;
                if (hit >= 0) begin
                    pm = attr[ins ? 4 : 3][2 * hit +: 2];
                    if (!(pm == 2'h0 || (!p && (pm == 2'h1 || (pm == 2'h2 && w)))))
                        model = {1'b0, attr[ins][hit], !ins && attr[2][hit]};
                end
            end
        end
    endfunction

    task finish_test;
        begin
            if (mismatches == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task chk_res(input [3:0] g, input [3:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0t check result %h expected %h", $time, g, e);
            end
        end
    endtask

    task chk_word(input [31:0] g, input [31:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0t read %h expected %h", $time, g, e);
            end
        end
    endtask

    task cp_write(input [3:0] r, input [2:0] o, input [2:0] c, input [31:0] d);
        begin
            @(posedge ref_clk);
            cp_wr <= 1'b1;
            cp_reg <= r;
            cp_opc2 <= o;
            cp_crm <= c;
            cp_wdata <= d;
            @(posedge ref_clk);
            cp_wr <= 1'b0;
        end
    endtask

    task cp_read(input [3:0] r, input [2:0] o, input [2:0] c, input [31:0] e);
        integer n;
        begin
            n = 0;
            @(posedge ref_clk);
            cp_rd <= 1'b1;
            cp_reg <= r;
            cp_opc2 <= o;
            cp_crm <= c;
            @(posedge ref_clk);
            cp_rd <= 1'b0;
            @(negedge ref_clk);
            while (cp_rvalid !== 1'b1 && n < 4) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            if (n == 4) begin
                mismatches = mismatches + 1;
                finish_test;
            end else begin
                chk_word(cp_rdata, e);
            end
        end
    endtask

    // expected results one cycle behind the requests
    always @(posedge ref_clk) begin
        exp_if <= (if_req && !sys_rst) ? {1'b1, model(if_addr, if_priv, 1'b0, 1'b1)} : 4'h0;
        exp_da <= (da_req && !sys_rst) ? {1'b1, model(da_addr, da_priv, da_write, 1'b0)} : 4'h0;
    end

    // compare each settled result
    always @(negedge ref_clk) begin
        if (!sys_rst) begin
            chk_res({if_valid, exp_if[3] ? {if_abort, if_cachable, 1'b0} : 3'h0}, exp_if);
            chk_res({da_valid, exp_da[3] ? {da_abort, da_cachable, da_bufferable} : 3'h0},
                exp_da);
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches = mismatches + 1;
        finish_test;
    end

    // reset, register checks, then random traffic over several configurations
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 8; k = k + 1) cp_read(4'h6, 3'h0, k[2:0], 32'h0);
        cp_read(4'h1, 3'h0, 3'h0, 32'h0);
        cp_read(4'h4, 3'h0, 3'h0, 32'h0);
        cp_read(4'h2, 3'h3, 3'h0, 32'h0);
        run <= 1'b1;
        repeat (60) @(posedge ref_clk);
        for (round = 0; round < 6; round = round + 1) begin
            run <= 1'b0;
            repeat (3) @(posedge ref_clk);
            for (k = 0; k < 8; k = k + 1) begin
                s = (k == 0 && round[0]) ? 31 : 11 + {$random(seed)} % 6;
                v = {$random(seed)} & 32'h0003FFFF;
                v = (v >> (s + 1)) << (s + 1);
                j = $random(seed);
                v[11:0] = {6'h3F, s[4:0], (k == 0) | j[0]};
                cp_write(4'h6, 3'h0, k[2:0], v);
                rgn[k] = v & 32'hFFFFF03F;
                cp_read(4'h6, 3'h0, k[2:0], rgn[k]);
            end
            for (j = 0; j < 5; j = j + 1) begin
                v = $random(seed);
                attr[j] = (j < 3) ? {24'h0, v[7:0]} : {16'h0, v[15:0]};
                if (j > 2) attr[j][1:0] = 2'h3;
                cp_write(4'h2 + (j == 2) + 3 * (j > 2), {2'h0, j == 1 || j == 4}, 3'h0, attr[j]);
                cp_read(4'h2 + (j == 2) + 3 * (j > 2), {2'h0, j == 1 || j == 4}, 3'h0,
                    attr[j]);
            end
            cp_write(4'h1, 3'h0, 3'h0, {31'h0, round != 5});
            en = (round != 5);
            cp_read(4'h1, 3'h0, 3'h0, {31'h0, round != 5});
            run <= 1'b1;
            repeat (300) @(posedge ref_clk);
        end
        finish_test;
    end
endmodule

// ### rtl/region_match.v
// one region comparator: enabled and upper address bits equal to base
`timescale 1ns/1ps
module region_match (
    input  wire [31:0] cfg,
    input  wire [31:0] addr,
    output wire        hit
);
`include "region_protection_unit_defines.vh"

    wire [4:0]  size_code;
    wire [19:0] bit_eq;

    assign size_code = cfg[`RGN_SIZE_HI:`RGN_SIZE_LO];

    // bit b lies inside the region when b <= size code, so it is not compared
    genvar i;
    generate
        for (i = 0; i < 20; i = i + 1) begin : g_bit
            localparam integer BIT_POS = i + 12;
            assign bit_eq[i] = ({27'h0000000, size_code} >= BIT_POS) ||
                               (addr[i + 12] == cfg[i + 12]); // R07 R17
        end
    endgenerate

    assign hit = cfg[`RGN_EN] & (&bit_eq); // R17
endmodule

// ### rtl/region_priority.v
// picks the highest-numbered hit among the region comparators
`timescale 1ns/1ps
module region_priority #(
    parameter N     = 8,
    parameter IDX_W = 3
) (
    input  wire [N-1:0]     hits,
    output reg              found,
    output reg  [IDX_W-1:0] index
);

    integer k;

    // later, higher-numbered hits overwrite lower ones
    always @* begin
        found = 1'b0;
        index = {IDX_W{1'b0}};
        for (k = 0; k < N; k = k + 1) begin
            if (hits[k]) begin
                found = 1'b1;
                index = k[IDX_W-1:0]; // R15
            end
        end
    end
endmodule

// ### rtl/region_protection_unit.v
// eight-region protection unit checking core fetches and data accesses
`timescale 1ns/1ps
`include "region_protection_unit_defines.vh"
module region_protection_unit #(
    parameter NUM_REGIONS = `NUM_REGIONS
) (
    input  wire        ref_clk,
    input  wire        sys_rst,
    // system control coprocessor register port
    input  wire        cp_wr,
    input  wire        cp_rd,
    input  wire [3:0]  cp_reg,
    input  wire [2:0]  cp_opc2,
    input  wire [2:0]  cp_crm,
    input  wire [31:0] cp_wdata,
    output reg  [31:0] cp_rdata,
    output reg         cp_rvalid,
    // instruction fetch check
    input  wire        if_req,
    input  wire [31:0] if_addr,
    input  wire        if_priv,
    output reg         if_valid,
    output reg         if_abort,
    output reg         if_cachable,
    // data access check
    input  wire        da_req,
    input  wire [31:0] da_addr,
    input  wire        da_priv,
    input  wire        da_write,
    output reg         da_valid,
    output reg         da_abort,
    output reg         da_cachable,
    output reg         da_bufferable,
    // unit state
    output reg         unit_enabled
);

    // programmable state
    reg  [31:0] control;
    reg  [7:0]  d_cachable;
    reg  [7:0]  i_cachable;
    reg  [7:0]  d_bufferable;
    reg  [15:0] d_perm;
    reg  [15:0] i_perm;
    reg  [31:0] region_cfg [0:NUM_REGIONS-1];

    // match results
    wire [NUM_REGIONS-1:0] if_hits;
    wire [NUM_REGIONS-1:0] da_hits;
    wire                   if_found;
    wire                   da_found;
    wire [2:0]             if_index;
    wire [2:0]             da_index;

    // combinational check results
    reg         next_if_abort;
    reg         next_if_cachable;
    reg         next_da_abort;
    reg         next_da_cachable;
    reg         next_da_bufferable;
    reg  [31:0] next_cp_rdata;
    reg  [1:0]  if_perm_sel;
    reg  [1:0]  da_perm_sel;

    wire        unit_en;

    // decoded write strobes, one per register copy
    wire        wr_control;
    wire        wr_d_cachable;
    wire        wr_i_cachable;
    wire        wr_bufferable;
    wire        wr_d_perm;
    wire        wr_i_perm;
    wire        wr_region;

    assign unit_en = control[`CTRL_UNIT_EN]; // R02

    // write strobes: register number, plus the copy select for 2 and 5
    assign wr_control    = cp_wr && (cp_reg == `CPREG_CONTROL);
    assign wr_d_cachable = cp_wr && (cp_reg == `CPREG_CACHABLE) && (cp_opc2 == `SEL_DATA);
    assign wr_i_cachable = cp_wr && (cp_reg == `CPREG_CACHABLE) && (cp_opc2 == `SEL_INSTR);
    assign wr_bufferable = cp_wr && (cp_reg == `CPREG_BUFFERABLE);
    assign wr_d_perm     = cp_wr && (cp_reg == `CPREG_PERMISSION) && (cp_opc2 == `SEL_DATA);
    assign wr_i_perm     = cp_wr && (cp_reg == `CPREG_PERMISSION) && (cp_opc2 == `SEL_INSTR);
    assign wr_region     = cp_wr && (cp_reg == `CPREG_REGION);

    // permission decode: true when the access is allowed
    function perm_ok;
        input [1:0] perm;
        input       priv;
        input       write;
        begin
            case (perm)
                `PERM_NONE:      perm_ok = 1'b0;
                `PERM_PRIV_ONLY: perm_ok = priv;
                `PERM_USER_RO:   perm_ok = priv | ~write;
                default:         perm_ok = 1'b1;
            endcase
        end
    endfunction

    // one comparator per region for each of the two access streams
    genvar r;
    generate
        for (r = 0; r < NUM_REGIONS; r = r + 1) begin : g_region
            region_match u_if_match (
                .cfg  (region_cfg[r]),
                .addr (if_addr),
                .hit  (if_hits[r])
            ); // R01 R17
            region_match u_da_match (
                .cfg  (region_cfg[r]),
                .addr (da_addr),
                .hit  (da_hits[r])
            ); // R01 R17
        end
    endgenerate

    // highest-numbered matching region wins on overlap
    region_priority #(
        .N     (NUM_REGIONS),
        .IDX_W (`REGION_IDX_W)
    ) u_if_prio (
        .hits  (if_hits),
        .found (if_found),
        .index (if_index)
    ); // R15

    region_priority #(
        .N     (NUM_REGIONS),
        .IDX_W (`REGION_IDX_W)
    ) u_da_prio (
        .hits  (da_hits),
        .found (da_found),
        .index (da_index)
    ); // R15

    // instruction fetch check: a fetch is a read, so write is zero
    always @* begin
        if_perm_sel      = i_perm[2*if_index +: 2];
        next_if_abort    = 1'b0;
        next_if_cachable = 1'b0; // R03
        if (unit_en) begin
            if (!if_found) begin
                next_if_abort = 1'b1; // R16
            end else if (!perm_ok(if_perm_sel, if_priv, 1'b0)) begin
                next_if_abort = 1'b1; // R10
            end else begin
                next_if_cachable = i_cachable[if_index]; // R09
            end
        end
    end

    // data access check, with bufferable only on this stream
    always @* begin
        da_perm_sel        = d_perm[2*da_index +: 2];
        next_da_abort      = 1'b0;
        next_da_cachable   = 1'b0; // R03
        next_da_bufferable = 1'b0; // R03
        if (unit_en) begin
            if (!da_found) begin
                next_da_abort = 1'b1; // R16
            end else if (!perm_ok(da_perm_sel, da_priv, da_write)) begin
                next_da_abort = 1'b1; // R10
            end else begin
                next_da_cachable   = d_cachable[da_index];   // R11
                next_da_bufferable = d_bufferable[da_index]; // R09 R11
            end
        end
    end

    // fetch check outputs land one cycle after the request
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            if_valid    <= 1'b0;
            if_abort    <= 1'b0;
            if_cachable <= 1'b0;
        end else begin
            if_valid    <= if_req;
            if_abort    <= if_req & next_if_abort;    // R10
            if_cachable <= if_req & next_if_cachable; // R03
        end
    end

    // data check outputs, same timing as the fetch side
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            da_valid      <= 1'b0;
            da_abort      <= 1'b0;
            da_cachable   <= 1'b0;
            da_bufferable <= 1'b0;
        end else begin
            da_valid      <= da_req;
            da_abort      <= da_req & next_da_abort;      // R10
            da_cachable   <= da_req & next_da_cachable;   // R03
            da_bufferable <= da_req & next_da_bufferable; // R03
        end
    end

    // registered copy of the unit enable, one cycle behind the control bit
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            unit_enabled <= 1'b0;
        end else begin
            unit_enabled <= unit_en; // R02
        end
    end

    // control register: every bit stored, only bit 0 acts
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            control <= `CONTROL_RESET;
        end else if (wr_control) begin
            control <= cp_wdata; // R02 R14
        end
    end

    // data cachable bits, bit n belongs to region n
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            d_cachable <= `ATTR_RESET;
        end else if (wr_d_cachable) begin
            d_cachable <= cp_wdata[7:0]; // R09 R14
        end
    end

    // instruction cachable bits
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            i_cachable <= `ATTR_RESET;
        end else if (wr_i_cachable) begin
            i_cachable <= cp_wdata[7:0]; // R09 R14
        end
    end

    // data bufferable bits; fetches have no bufferable copy
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            d_bufferable <= `ATTR_RESET;
        end else if (wr_bufferable) begin
            d_bufferable <= cp_wdata[7:0]; // R09 R14
        end
    end

    // data permissions, two bits per region
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            d_perm <= `PERM_RESET;
        end else if (wr_d_perm) begin
            d_perm <= cp_wdata[15:0]; // R14
        end
    end

    // instruction permissions, two bits per region
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            i_perm <= `PERM_RESET;
        end else if (wr_i_perm) begin
            i_perm <= cp_wdata[15:0]; // R14
        end
    end

    // region base and size registers, enables clear at reset
    generate
        for (r = 0; r < NUM_REGIONS; r = r + 1) begin : g_cfg
            always @(posedge ref_clk) begin
                if (sys_rst) begin
                    region_cfg[r] <= `REGION_RESET; // R05
                end else if (wr_region && cp_crm == r) begin
                    region_cfg[r] <= cp_wdata & `RGN_WRITE_MASK; // R04 R14
                end
            end
        end
    endgenerate

    // coprocessor read decode; unmapped selections read zero
    always @* begin
        next_cp_rdata = 32'h00000000;
        if (cp_reg == `CPREG_CONTROL) begin
            next_cp_rdata = control;
        end else if (cp_reg == `CPREG_CACHABLE) begin
            if (cp_opc2 == `SEL_DATA) begin
                next_cp_rdata = {24'h000000, d_cachable};
            end else if (cp_opc2 == `SEL_INSTR) begin
                next_cp_rdata = {24'h000000, i_cachable};
            end
        end else if (cp_reg == `CPREG_BUFFERABLE) begin
            next_cp_rdata = {24'h000000, d_bufferable};
        end else if (cp_reg == `CPREG_PERMISSION) begin
            if (cp_opc2 == `SEL_DATA) begin
                next_cp_rdata = {16'h0000, d_perm};
            end else if (cp_opc2 == `SEL_INSTR) begin
                next_cp_rdata = {16'h0000, i_perm};
            end
        end else if (cp_reg == `CPREG_REGION) begin
            next_cp_rdata = region_cfg[cp_crm]; // R04
        end
    end

    // read data is registered and flagged for one cycle
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cp_rdata  <= 32'h00000000;
            cp_rvalid <= 1'b0;
        end else begin
            cp_rvalid <= cp_rd;
            if (cp_rd) begin
                cp_rdata <= next_cp_rdata; // R14
            end
        end
    end

endmodule

// ### rtl/region_protection_unit_defines.vh
// constants for the region protection unit: register numbers, fields, resets
// Operation
// [R01] Eight independently programmable regions of variable size cover the address space.
// [R02] Control register bit 0 set enables the unit; clear disables it.
// [R03] Unit disabled: fetches noncachable, data noncachable and nonbufferable.
// [R04] Region register: base 31:12, unused 11:6, size code 5:1, enable bit 0.
// [R05] Every region enable resets to zero, so all regions start disabled.
// [R06] Software aligns each region base to a multiple of its size.
// [R07] Size code 01011 is 4KB; each higher code doubles, 11111 is 4GB.
// [R08] Software never writes size codes 00000 to 01010; they are reserved.
// [R09] Regions carry cachable and permissions; bufferable applies to data regions only.
// [R10] Failed permission check aborts: prefetch abort for fetches, data abort otherwise.
// [R11] Cachable and bufferable together pick one of four cache/buffer behaviours.
// [R12] Software programs a valid region before setting the unit enable.
// [R13] Software gives code memory a region allowing instruction and data access.
// [R14] Configuration sits in coprocessor registers 1, 2, 3, 5 and 6.
// [R15] Overlapping matches take the highest-numbered region; 7 highest, 0 lowest.
// [R16] An access matching no enabled region is always aborted. The code aborts it only while the unit is enabled.
// [R17] A region matches when enabled and address bits above its size equal base.
`ifndef REGION_PROTECTION_UNIT_DEFINES_VH
`define REGION_PROTECTION_UNIT_DEFINES_VH

`define NUM_REGIONS       8
`define REGION_IDX_W      3

// coprocessor register numbers
`define CPREG_CONTROL     4'h1
`define CPREG_CACHABLE    4'h2
`define CPREG_BUFFERABLE  4'h3
`define CPREG_PERMISSION  4'h5
`define CPREG_REGION      4'h6

// second opcode selects data or instruction copy of registers 2 and 5
`define SEL_DATA          3'h0
`define SEL_INSTR         3'h1

// control register fields
`define CTRL_UNIT_EN      0

// region register fields
`define RGN_BASE_HI       31
`define RGN_BASE_LO       12
`define RGN_SIZE_HI       5
`define RGN_SIZE_LO       1
`define RGN_EN            0
`define RGN_WRITE_MASK    32'hFFFFF03F

// permission codes, two bits per region
`define PERM_NONE         2'h0
`define PERM_PRIV_ONLY    2'h1
`define PERM_USER_RO      2'h2
`define PERM_FULL         2'h3

// reset values
`define CONTROL_RESET     32'h00000000
`define ATTR_RESET        8'h00
`define PERM_RESET        16'h0000
`define REGION_RESET      32'h00000000

`endif
